// *** design/sui_pkg.sv ***
// Shared constants, carriers and helpers of the serial wake-up and interrupt block.
// Assumes a single 200 MHz bus-cycle clock; every count is in bus cycles.
package sui_pkg;

  // ----------------------------------------
  // Bit rate
  // ----------------------------------------
  localparam logic [1:0] SPD_16 = 2'h0;
  localparam logic [1:0] SPD_128 = 2'h1;
  localparam logic [1:0] SPD_1024 = 2'h2;
  localparam logic [1:0] SPD_4096 = 2'h3;
  localparam int BIT_CNT_W = 12;
  localparam logic [11:0] BITM1_16 = 12'h00F;
  localparam logic [11:0] BITM1_128 = 12'h07F;
  localparam logic [11:0] BITM1_1024 = 12'h3FF;
  localparam logic [11:0] BITM1_4096 = 12'hFFF;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int CHAIN_W = 10;
  localparam logic [9:0] CHAIN_ONES = 10'h3FF;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] TX_REST_BITS = 4'h9;
  localparam logic START_LEVEL = 1'h0;
  localparam logic STOP_LEVEL = 1'h1;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic status_read;
    logic data_read;
    logic tx_write;
    logic [7:0] tx_data;
    logic sleep_set;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic cpu_irq_mask;
    logic [1:0] speed_select;
  } sui_cpu_t;

  typedef struct packed {
    logic rx_full_flag;
    logic overrun_framing_flag;
    logic tx_buffer_empty_flag;
    logic sleep_until_idle;
    logic [7:0] rx_data;
  } sui_status_t;

  typedef enum logic {RX_HUNT, RX_FRAME} sui_rx_state_t;

  // Bus cycles per bit, less one, for a speed-select code.
  function automatic logic [11:0] sui_bit_m1(input logic [1:0] spd);
    logic [11:0] r;
    r = BITM1_16;
    unique case (spd)
      SPD_16: r = BITM1_16;
      SPD_128: r = BITM1_128;
      SPD_1024: r = BITM1_1024;
      SPD_4096: r = BITM1_4096;
    endcase
    return r;
  endfunction

endpackage

// *** design/sui_sync.sv ***
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module sui_sync
  import sui_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'h1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Level
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sui_sync_st_t;

  sui_sync_st_t st;
  sui_sync_st_t next_st;

  always_comb
  begin
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st <= {RESET_LEVEL, RESET_LEVEL};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule
`default_nettype wire

// *** design/sui_bitclk.sv ***
// Down-counting bit-time divider with a restart to the half-bit point.
// Assumes period_m1 is steady during use; restart has priority over counting.
`timescale 1ns/1ps
`default_nettype none
module sui_bitclk
  import sui_pkg::*;
#(
  parameter int W = BIT_CNT_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic [W-1:0] period_m1,
  input wire logic restart,
  // Bit tick
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } sui_div_st_t;

  sui_div_st_t st;
  sui_div_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (restart)
    begin
      next_st.cnt = period_m1 >> 1;
    end
    else if (st.cnt == '0)
    begin
      next_st.cnt = period_m1;
    end
    else
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick = (st.cnt == '0) && !restart;

endmodule
`default_nettype wire

// *** design/sui_wakeup_irq.sv ***
// Receiver wake-up, flag handling, transmitter and interrupt request of a serial port.
// Assumes CPU strobes are one-cycle pulses on clk; the line input is asynchronous.
//
// What this block does
// - Sleep freezes receive-full until ten-bit idle.
// - Ten received ones clear sleep, receiver resumes.
// - Data, stop and idle ones all count.
// - Sleep clears when whole receive chain holds ones.
// - Transmit frame is ten bits, idle high after.
// - Buffer-empty sets when byte enters shifter.
// - Speed select gives 16/128/1024/4096 cycles per bit.
// - Sleep with receive-full clear also hides framing error.
// - After wake, next good byte sets receive-full.
// - Valid byte overrun by misframed: both flags, keep.
// - Framing error then overruns: framing report, keep first.
// - Two enables gate three conditions onto one request.
// - Receive request on full, error, or both.
// - Status read then data read clears receive flags.
// - Transmit request needs buffer-empty and its enable.
// - Start bit zero, one stop bit, no parity.
// - Data write counts only after status read.
`timescale 1ns/1ps
`default_nettype none
module sui_wakeup_irq
  import sui_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // CPU side
  input wire sui_cpu_t cpu,
  output sui_status_t status,
  output logic irq,
  // Serial line
  input wire logic rx_line,
  output logic tx_line
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sui_rx_state_t rx_st;
    logic [9:0] chain;
    logic [3:0] nsamp;
    logic line_prev;
    logic rx_full;
    logic rx_error;
    logic [7:0] rx_data;
    logic armed_rx;
    logic armed_tx;
    logic sleep;
    logic tx_empty;
    logic [7:0] tdr;
    logic [9:0] tx_shift;
    logic [3:0] tx_left;
    logic tx_out;
  } sui_state_t;

  sui_state_t st;
  sui_state_t next_st;
  logic line_s;
  logic rx_tick;
  logic tx_tick;
  logic rx_restart;
  logic frame_done;
  logic idle_seen;
  logic tx_load;
  logic [11:0] bit_m1;
  logic [9:0] shifted;

  // ----------------------------------------
  // Line input and bit timing
  // ----------------------------------------
  sui_sync #(.RESET_LEVEL(1'h1)) u_rx_sync (
    .clk(clk),
    .reset(reset),
    .async_in(rx_line),
    .sync_out(line_s)
  );

  assign bit_m1 = sui_bit_m1(cpu.speed_select);
  assign rx_restart = (st.rx_st == RX_HUNT) && st.line_prev && !line_s;

  sui_bitclk #(.W(BIT_CNT_W)) u_rx_clk (
    .clk(clk),
    .reset(reset),
    .period_m1(bit_m1),
    .restart(rx_restart),
    .tick(rx_tick)
  );

  sui_bitclk #(.W(BIT_CNT_W)) u_tx_clk (
    .clk(clk),
    .reset(reset),
    .period_m1(bit_m1),
    .restart(1'b0),
    .tick(tx_tick)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign shifted = {line_s, st.chain[9:1]};
  assign frame_done = (st.rx_st == RX_FRAME) && rx_tick && (st.nsamp == FRAME_LAST);
  assign idle_seen = (st.chain == CHAIN_ONES);
  assign tx_load = tx_tick && (st.tx_left == '0) && !st.tx_empty;

  always_comb
  begin
    next_st = st;
    next_st.line_prev = line_s;
    // Receiver sampling chain.
    unique case (st.rx_st)
      RX_HUNT:
      begin
        if (rx_restart)
        begin
          next_st.rx_st = RX_FRAME;
          next_st.nsamp = '0;
        end
        else if (rx_tick)
        begin
          next_st.chain = shifted;
        end
      end
      RX_FRAME:
      begin
        if (rx_tick)
        begin
          next_st.chain = shifted;
          next_st.nsamp = st.nsamp + 1'b1;
          if (st.nsamp == '0 && line_s != START_LEVEL)
          begin
            next_st.rx_st = RX_HUNT;
          end
          else if (st.nsamp == FRAME_LAST)
          begin
            next_st.rx_st = RX_HUNT;
          end
        end
      end
    endcase
    // CPU clear sequence on the receive side.
    if (cpu.status_read && (st.rx_full || st.rx_error))
    begin
      next_st.armed_rx = 1'b1;
    end
    if (cpu.data_read && st.armed_rx)
    begin
      next_st.rx_full = 1'b0;
      next_st.rx_error = 1'b0;
      next_st.armed_rx = 1'b0;
    end
    // Frame evaluation; a set here wins over a clear in the same cycle.
    if (frame_done)
    begin
      if (st.sleep)
      begin
        if (st.rx_full)
        begin
          next_st.rx_error = 1'b1;
        end
      end
      else if (st.rx_full)
      begin
        next_st.rx_full = 1'b1;
        next_st.rx_error = 1'b1;
      end
      else if (!st.rx_error)
      begin
        next_st.rx_data = shifted[8:1];
        if (line_s == STOP_LEVEL)
        begin
          next_st.rx_full = 1'b1;
        end
        else
        begin
          next_st.rx_error = 1'b1;
        end
      end
      else
      begin
        next_st.rx_error = 1'b1;
      end
    end
    // Sleep control; hardware idle clear has priority.
    if (idle_seen)
    begin
      next_st.sleep = 1'b0;
    end
    else if (cpu.sleep_set)
    begin
      next_st.sleep = 1'b1;
    end
    // Transmit data register.
    if (cpu.status_read && st.tx_empty)
    begin
      next_st.armed_tx = 1'b1;
    end
    if (cpu.tx_write && st.armed_tx)
    begin
      next_st.tdr = cpu.tx_data;
      next_st.tx_empty = 1'b0;
      next_st.armed_tx = 1'b0;
    end
    // Transmit shifter.
    if (tx_tick)
    begin
      if (st.tx_left != '0)
      begin
        next_st.tx_out = st.tx_shift[0];
        next_st.tx_shift = {STOP_LEVEL, st.tx_shift[9:1]};
        next_st.tx_left = st.tx_left - 1'b1;
      end
      else if (!st.tx_empty)
      begin
        next_st.tx_out = START_LEVEL;
        next_st.tx_shift = {STOP_LEVEL, STOP_LEVEL, st.tdr};
        next_st.tx_left = TX_REST_BITS;
        next_st.tx_empty = 1'b1;
      end
      else
      begin
        next_st.tx_out = STOP_LEVEL;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      st.rx_st <= RX_HUNT;
      st.chain <= CHAIN_ONES;
      st.line_prev <= 1'b1;
      st.tx_empty <= 1'b1;
      st.tx_out <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign status.rx_full_flag = st.rx_full;
  assign status.overrun_framing_flag = st.rx_error;
  assign status.tx_buffer_empty_flag = st.tx_empty;
  assign status.sleep_until_idle = st.sleep;
  assign status.rx_data = st.rx_data;
  assign tx_line = st.tx_out;
  assign irq = !cpu.cpu_irq_mask &&
    ((cpu.rx_irq_enable && (st.rx_full || st.rx_error)) ||
     (cpu.tx_irq_enable && st.tx_empty));

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_gating: assert property (@(posedge clk) disable iff (reset)
    irq == (!cpu.cpu_irq_mask && ((cpu.rx_irq_enable && (status.rx_full_flag ||
      status.overrun_framing_flag)) || (cpu.tx_irq_enable && status.tx_buffer_empty_flag))))
    else $error("Interrupt request does not match flags and enables.");

  a_tx_irq_only: assert property (@(posedge clk) disable iff (reset)
    (!cpu.rx_irq_enable && irq) |-> (status.tx_buffer_empty_flag && cpu.tx_irq_enable))
    else $error("Transmit request without buffer-empty and enable.");

  a_wake_clear: assert property (@(posedge clk) disable iff (reset)
    (st.sleep && idle_seen) |=> !status.sleep_until_idle)
    else $error("Sleep not cleared after ten ones.");

  a_wake_prio: assert property (@(posedge clk) disable iff (reset)
    (cpu.sleep_set && idle_seen) |=> !status.sleep_until_idle)
    else $error("Sleep set won over idle detection.");

  a_sleep_hold: assert property (@(posedge clk) disable iff (reset)
    (status.sleep_until_idle && !status.rx_full_flag) |=> !status.rx_full_flag)
    else $error("Receive-full set while asleep.");

  a_sleep_no_err: assert property (@(posedge clk) disable iff (reset)
    (status.sleep_until_idle && !status.rx_full_flag && !status.overrun_framing_flag)
      |=> !status.overrun_framing_flag)
    else $error("Overrun/framing set while asleep with receive-full clear.");

  a_overrun_keep: assert property (@(posedge clk) disable iff (reset)
    (frame_done && st.rx_full && !st.sleep) |=>
      (status.rx_full_flag && status.overrun_framing_flag && $stable(status.rx_data)))
    else $error("Overrun did not keep held byte with both flags.");

  a_framing_keep: assert property (@(posedge clk) disable iff (reset)
    (frame_done && st.rx_error && !st.rx_full && !st.sleep) |=>
      (!status.rx_full_flag && status.overrun_framing_flag && $stable(status.rx_data)))
    else $error("Framing error report lost or data replaced.");

  a_rx_clear_seq: assert property (@(posedge clk) disable iff (reset)
    (cpu.data_read && !st.armed_rx && st.rx_full) |=> status.rx_full_flag)
    else $error("Receive-full cleared without status read first.");

  a_tx_buffer_empty_flag_on_load: assert property (@(posedge clk) disable iff (reset)
    tx_load |=> (status.tx_buffer_empty_flag && tx_line == START_LEVEL))
    else $error("Buffer-empty not set or no start bit at load.");

  a_tx_stop_bit: assert property (@(posedge clk) disable iff (reset)
    (tx_tick && st.tx_left == 4'h1) |=> (tx_line == STOP_LEVEL && st.tx_left == '0))
    else $error("Tenth transmitted bit is not a stop bit.");

  a_write_gate: assert property (@(posedge clk) disable iff (reset)
    (cpu.tx_write && !st.armed_tx && st.tx_empty) |=> status.tx_buffer_empty_flag)
    else $error("Unarmed write cleared buffer-empty.");

  c_overrun: cover property (@(posedge clk) disable iff (reset)
    frame_done && st.rx_full && !st.sleep);

  c_framing: cover property (@(posedge clk) disable iff (reset)
    frame_done && !st.sleep && !st.rx_full && !st.rx_error && line_s == 1'b0);

  c_wake: cover property (@(posedge clk) disable iff (reset)
    st.sleep ##1 !st.sleep);

  c_tx_load: cover property (@(posedge clk) disable iff (reset)
    tx_load);

endmodule
`default_nettype wire

// *** verification/sui_peer_tx.sv ***
// Peer transmitter that drives the shared serial line in place of another processor.
// Assumes its tasks are called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module sui_peer_tx
  import sui_pkg::*;
(
  // Clock
  input wire logic clk,
  // Shared line
  output logic line
);
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  int bit_cycles = 16;

  initial line = 1'b1;

  // Sends one frame; a stop level of zero gives a misframed character.
  task automatic send(input logic [7:0] b, input logic stop, input int idle_bits);
    logic [9:0] f;
    f = {stop, b, START_LEVEL};
    for (int i = 0; i < 10; i++)
    begin
      line = f[i];
      repeat (bit_cycles) @(posedge clk);
      #1;
    end
    if (idle_bits > 0)
      idle(idle_bits);
  endtask

  // Holds the line at its idle level for a number of bit times.
  task automatic idle(input int bits);
    line = 1'b1;
    repeat (bits * bit_cycles) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** verification/sui_wakeup_irq_bench.sv ***
// Self-checking testbench of the serial wake-up and interrupt block.
// Assumes the peer model drives the receive line and CPU strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module sui_wakeup_irq_bench
  import sui_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  sui_cpu_t cpu = '0;
  sui_status_t status;
  logic irq;
  logic rx_line;
  logic tx_line;
  int n_fail = 0;
  int num_checks = 0;
  int cpb[4] = '{16, 128, 1024, 4096};

  always #2.5 clk = ~clk;

  sui_wakeup_irq i_dut (.clk(clk), .reset(reset), .cpu(cpu), .status(status), .irq(irq),
    .rx_line(rx_line), .tx_line(tx_line));
  sui_peer_tx i_peer (.clk(clk), .line(rx_line));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares {rx full, overrun/framing, buffer empty, sleep}.
  task automatic chk_st(input logic [3:0] exp);
    chk({4'h0, status.rx_full_flag, status.overrun_framing_flag,
      status.tx_buffer_empty_flag, status.sleep_until_idle}, {4'h0, exp});
  endtask

  // Pulses {status read, data read, tx write, sleep set} for one cycle, then idles one cycle.
  task automatic strobe(input logic [3:0] m);
    {cpu.status_read, cpu.data_read, cpu.tx_write, cpu.sleep_set} = m;
    step();
    {cpu.status_read, cpu.data_read, cpu.tx_write, cpu.sleep_set} = 4'h0;
    step();
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Waits for a start bit on tx_line and samples every bit at mid-bit.
  task automatic tx_frame(input int s, input logic [7:0] b);
    int k;
    logic [9:0] f;
    k = 0;
    f = {STOP_LEVEL, b, START_LEVEL};
    while (tx_line === 1'b1 && k < 10000)
    begin
      step();
      k++;
    end
    if (k >= 10000)
    begin
      chk({7'h0, tx_line}, 8'h00);
      test_done();
    end
    chk({7'h0, status.tx_buffer_empty_flag}, 8'h01);
    step(cpb[s] / 2 - 1);
    for (int i = 0; i < 11; i++)
    begin
      chk({7'h0, tx_line}, (i < 10) ? {7'h0, f[i]} : 8'h01);
      step(cpb[s]);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    step(20);
    reset = 1'b0;
    step();
    chk_st(4'b0010);
    chk(status.rx_data, 8'h00);
    chk({7'h0, tx_line, irq}, 8'h02);
    // A write with no status read since reset is refused.
    cpu.tx_data = 8'h99;
    strobe(4'h2);
    step();
    chk_st(4'b0010);
    step(400);
    chk({7'h0, tx_line}, 8'h01);
    cpu.tx_irq_enable = 1'b1;
    step();
    chk({7'h0, irq}, 8'h01);
    cpu.cpu_irq_mask = 1'b1;
    step();
    chk({7'h0, irq}, 8'h00);
    cpu.cpu_irq_mask = 1'b0;
    cpu.tx_irq_enable = 1'b0;
    cpu.rx_irq_enable = 1'b1;
    // Receive, overrun and framing cases.
    i_peer.send(8'hA5, 1'b1, 2);
    chk_st(4'b1010);
    chk(status.rx_data, 8'hA5);
    chk({7'h0, irq}, 8'h01);
    strobe(4'h4);
    step();
    chk_st(4'b1010);
    i_peer.send(8'h0F, 1'b0, 2);
    chk_st(4'b1110);
    chk(status.rx_data, 8'hA5);
    chk({7'h0, irq}, 8'h01);
    cpu.cpu_irq_mask = 1'b1;
    step();
    chk({7'h0, irq}, 8'h00);
    cpu.cpu_irq_mask = 1'b0;
    strobe(4'h8);
    strobe(4'h4);
    step();
    chk_st(4'b0010);
    chk({7'h0, irq}, 8'h00);
    i_peer.send(8'h5A, 1'b0, 2);
    chk_st(4'b0110);
    chk({7'h0, irq}, 8'h01);
    i_peer.send(8'h11, 1'b1, 2);
    chk_st(4'b0110);
    chk(status.rx_data, 8'h5A);
    strobe(4'h8);
    strobe(4'h4);
    // Sleep inside a message, wake on ten ones.
    i_peer.send(8'h41, 1'b1, 0);
    strobe(4'h8);
    strobe(4'h4);
    strobe(4'h1);
    step();
    chk_st(4'b0011);
    i_peer.send(8'h7F, 1'b1, 0);
    i_peer.send(8'hFE, 1'b1, 0);
    chk_st(4'b0011);
    i_peer.idle(3);
    chk_st(4'b0010);
    i_peer.send(8'h66, 1'b1, 2);
    chk_st(4'b1010);
    chk(status.rx_data, 8'h66);
    strobe(4'h1);
    step();
    chk_st(4'b1011);
    i_peer.send(8'h00, 1'b1, 2);
    chk_st(4'b1111);
    chk(status.rx_data, 8'h66);
    i_peer.idle(10);
    chk_st(4'b1110);
    strobe(4'h1);
    step();
    chk_st(4'b1110);
    strobe(4'h8);
    strobe(4'h4);
    // Transmit: one frame at every speed.
    cpu.rx_irq_enable = 1'b0;
    cpu.tx_irq_enable = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      cpu.speed_select = s[1:0];
      strobe(4'h8);
      cpu.tx_data = 8'h3C;
      strobe(4'h2);
      step();
      if (s == 3)
        chk({6'h0, status.tx_buffer_empty_flag, irq}, 8'h00);
      tx_frame(s, 8'h3C);
    end
    cpu.tx_irq_enable = 1'b0;
    step();
    chk({7'h0, irq}, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
